// [fswp_pkg.sv]
// Shared constants and types of the flash status and write-protect block
package fswp_pkg;

    // Low status register field positions
    localparam int unsigned BIT_BUSY = 0;
    localparam int unsigned BIT_LATCH = 1;
    localparam int unsigned BIT_GUARD_LSB = 2;
    localparam int unsigned GUARD_WIDTH = 5;
    localparam int unsigned BIT_LOCK_SEL_0 = 7;

    // High status register field positions, bit 0 is the ninth status bit
    localparam int unsigned BIT_LOCK_SEL_1 = 0;
    localparam int unsigned BIT_QUAD = 1;
    localparam int unsigned BIT_SEC_LOCK_LSB = 2;
    localparam int unsigned BIT_DUMMY = 4;
    localparam int unsigned BIT_RESERVED = 5;
    localparam int unsigned BIT_INVERT = 6;
    localparam int unsigned BIT_PAUSED = 7;

    // Values after reset
    localparam logic [7:0] LOW_RESET = 8'h00;
    localparam logic [7:0] HIGH_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // Lock select codes, written as {select 1, select 0}
    localparam logic [1:0] LOCK_SOFT = 2'h0;
    localparam logic [1:0] LOCK_PIN = 2'h1;
    localparam logic [1:0] LOCK_POWER = 2'h2;
    localparam logic [1:0] LOCK_ONCE = 2'h3;

    // Array geometry, 256 KB in 64 KB blocks and 4 KB slices
    localparam int unsigned ARRAY_ADDR_WIDTH = 18;
    localparam logic [18:0] ARRAY_BYTES = 19'h40000;
    localparam logic [18:0] BLOCK_BYTES = 19'h10000;
    localparam logic [18:0] SLICE_BYTES = 19'h01000;
    localparam logic [17:0] BLOCK_MASK = 18'h0FFFF;

    // Dummy cycles of the dual input/output fast read
    localparam logic [3:0] DUMMY_LOW = 4'h4;
    localparam logic [3:0] DUMMY_HIGH = 4'h8;

    typedef enum logic [3:0] {
        CMD_WRITE_ENABLE = 4'h1,
        CMD_WRITE_DISABLE = 4'h2,
        CMD_STATUS_WRITE = 4'h3,
        CMD_PAGE_PROGRAM = 4'h4,
        CMD_FOUR_KILOBYTE_ERASE = 4'h5,
        CMD_BLOCK_ERASE = 4'h6,
        CMD_CHIP_ERASE = 4'h7,
        CMD_SUSPEND = 4'h8,
        CMD_RESUME = 4'h9,
        CMD_SOFT_RESET = 4'hA
    } fswp_cmd_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_PAUSED = 3'b100
    } fswp_state_type;

endpackage : fswp_pkg

// [fswp_status_protect.sv]
// Status registers, write gating and area protection of the serial flash
//
// Overview of operation
// R1 - Low status: lock0, guard4..0, latch, busy
// R2 - High status: paused, invert, reserved, dummy, locks, quad, lock1
// R3 - Busy high while program, erase or write runs
// R4 - Latch clear refuses writes, programs and erases
// R5 - Guard bits refuse program/erase inside protected range
// R6 - Hardware-protected mode leaves guard bits unchanged
// R7 - Whole erase only for guard 000/no invert or 111/invert
// R8 - Lock code 00: writes allowed after write enable
// R9 - Lock code 01: protect pin low blocks writes
// R10 - Lock code 10: blocked until power cycle clears
// R11 - Lock code 11: status writes refused for good; here reset returns the lock selects to 00
// R12 - Quad enable turns protect/pause pins into data lines
// R13 - Host keeps quad off when pins are tied
// R14 - Security locks reset low, set once, never clear
// R15 - Dummy select gives 4 or 8 cycles
// R16 - Inverted block codes protect the complement
// R17 - Inverted slice codes: 000 all, 111 none
// R18 - Guard4 low: 64 KB blocks; high: 4-32 KB slices
// R19 - Latch cleared by reset, disable, write, program, erase
// R20 - Suspend sets paused; resume or reset clears it
// R21 - Refused status write changes nothing, starts nothing
`timescale 1ns/1ps

module fswp_status_protect #(
    parameter int unsigned STATUS_CYCLES = 8,
    parameter int unsigned PROGRAM_CYCLES = 16,
    parameter int unsigned ERASE_CYCLES = 32
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic link_clock,
    input wire logic cmd_valid,
    input wire fswp_pkg::fswp_cmd_type cmd_code,
    input wire logic [23:0] cmd_addr,
    input wire logic [15:0] cmd_data,
    input wire logic protect_pin,
    output logic cmd_ready,
    output logic cmd_accept,
    output logic cmd_reject,
    output logic [7:0] status_low,
    output logic [7:0] status_high,
    output logic [3:0] dummy_cycles,
    output logic quad_mode
);
    import fswp_pkg::*;

    if (STATUS_CYCLES < 2 || PROGRAM_CYCLES < 2 || ERASE_CYCLES < 2 ||
        STATUS_CYCLES > 65535 || PROGRAM_CYCLES > 65535 || ERASE_CYCLES > 65535) begin : g_bad
        $error("Operation cycle counts must lie between 2 and 65535");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link side: hold one command until the core has taken it

    logic link_pending;
    logic next_link_pending;
    logic link_req;
    logic next_link_req;
    fswp_cmd_type link_code;
    fswp_cmd_type next_link_code;
    logic [23:0] link_addr;
    logic [23:0] next_link_addr;
    logic [15:0] link_data;
    logic [15:0] next_link_data;
    logic next_cmd_ready;
    logic link_ack_meta;
    logic link_ack_sync;
    logic req_seen;

    always_comb begin
        next_link_pending = link_pending;
        next_link_req = link_req;
        next_link_code = link_code;
        next_link_addr = link_addr;
        next_link_data = link_data;
        if (link_pending) begin
            if (link_ack_sync == link_req) begin
                next_link_pending = 1'b0;
            end
        end else if (cmd_valid) begin
            next_link_code = cmd_code;
            next_link_addr = cmd_addr;
            next_link_data = cmd_data;
            next_link_req = ~link_req;
            next_link_pending = 1'b1;
        end
        next_cmd_ready = ~next_link_pending;
    end

    // Fields stay still while pending, so the core may read them after the toggle
    always_ff @(posedge link_clock or posedge rst) begin
        if (rst) begin
            link_pending <= 1'b0;
            link_req <= 1'b0;
            link_code <= CMD_WRITE_DISABLE;
            link_addr <= 24'h000000;
            link_data <= 16'h0000;
            cmd_ready <= 1'b1;
            link_ack_meta <= 1'b0;
            link_ack_sync <= 1'b0;
        end else begin
            link_pending <= next_link_pending;
            link_req <= next_link_req;
            link_code <= next_link_code;
            link_addr <= next_link_addr;
            link_data <= next_link_data;
            cmd_ready <= next_cmd_ready;
            link_ack_meta <= req_seen;
            link_ack_sync <= link_ack_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Core side synchronisers

    logic req_meta;
    logic req_sync;
    logic pin_meta;
    logic pin_sync;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            req_meta <= link_req;
            req_sync <= req_meta;
            pin_meta <= protect_pin;
            pin_sync <= pin_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Protected range decode

    function automatic logic area_protected(input logic [4:0] guard, input logic invert,
                                            input logic [17:0] addr);
        logic [18:0] size;
        logic hit;
        size = 19'h00000;
        if (!guard[4]) begin
            unique case (guard[1:0])
                2'h0: size = 19'h00000;
                2'h1: size = BLOCK_BYTES;
                2'h2: size = BLOCK_BYTES << 1;
                default: size = ARRAY_BYTES;
            endcase
        end else begin
            unique case (guard[2:0])
                3'h0: size = 19'h00000;
                3'h1: size = SLICE_BYTES;
                3'h2: size = SLICE_BYTES << 1;
                3'h3: size = SLICE_BYTES << 2;
                3'h7: size = ARRAY_BYTES;
                default: size = SLICE_BYTES << 3;
            endcase
        end
        // Guard bit 3 picks the bottom of the array, otherwise the top
        hit = guard[3] ? ({1'b0, addr} < size) : ({1'b0, addr} >= ARRAY_BYTES - size); // [R18]
        return hit ^ invert; // [R16] [R17]
    endfunction : area_protected

    ////////////////////////////////////////////////////////////////////////////////
    // Core: status registers and command execution

    fswp_state_type state;
    fswp_state_type next_state;
    logic [15:0] count;
    logic [15:0] next_count;
    logic [7:0] next_status_low;
    logic [7:0] next_status_high;
    logic next_req_seen;
    logic next_accept;
    logic next_reject;
    logic new_req;
    logic latch;
    logic [4:0] guard;
    logic invert;
    logic [1:0] lock_code;
    logic pin_level;
    logic write_allowed;
    logic chip_ok;
    logic [17:0] first_addr;
    logic [17:0] last_addr;
    logic target_protected;

    assign new_req = req_sync != req_seen;
    assign latch = status_low[BIT_LATCH];
    assign guard = status_low[BIT_GUARD_LSB +: GUARD_WIDTH];
    assign invert = status_high[BIT_INVERT];
    assign lock_code = {status_high[BIT_LOCK_SEL_1], status_low[BIT_LOCK_SEL_0]};
    // In quad mode the protect pin is a data line and no longer guards
    assign pin_level = status_high[BIT_QUAD] | pin_sync; // [R12]
    assign chip_ok = (guard[2:0] == 3'h0 && !invert) || (guard[2:0] == 3'h7 && invert); // [R7]

    always_comb begin
        unique case (lock_code)
            LOCK_SOFT: write_allowed = 1'b1; // [R8]
            LOCK_PIN: write_allowed = pin_level; // [R9] [R6]
            LOCK_POWER: write_allowed = 1'b0; // [R10]
            LOCK_ONCE: write_allowed = 1'b0; // [R11]
        endcase
    end

    // Ranges are contiguous, so a block clashes iff its first or last byte does
    always_comb begin
        first_addr = link_addr[ARRAY_ADDR_WIDTH-1:0];
        last_addr = first_addr;
        if (link_code == CMD_BLOCK_ERASE) begin
            first_addr = link_addr[ARRAY_ADDR_WIDTH-1:0] & ~BLOCK_MASK;
            last_addr = link_addr[ARRAY_ADDR_WIDTH-1:0] | BLOCK_MASK;
        end
        target_protected = area_protected(guard, invert, first_addr) |
                           area_protected(guard, invert, last_addr); // [R5]
    end

    always_comb begin
        next_state = state;
        next_count = count;
        next_status_low = status_low;
        next_status_high = status_high;
        next_req_seen = req_seen;
        next_accept = 1'b0;
        next_reject = 1'b0;
        if (state == ST_RUN) begin
            next_count = count - 16'h0001;
            if (count == 16'h0001) begin
                next_state = ST_IDLE;
            end
        end
        if (new_req) begin
            next_req_seen = req_sync;
            next_reject = 1'b1;
            unique case (link_code)
                CMD_SOFT_RESET: begin
                    next_state = ST_IDLE; // [R20]
                    next_count = COUNT_RESET;
                    next_status_low[BIT_LATCH] = 1'b0; // [R19]
                    next_reject = 1'b0;
                end
                CMD_SUSPEND: begin
                    // A suspend in the last busy cycle is too late to take
                    if (state == ST_RUN && count > 16'h0001) begin
                        next_state = ST_PAUSED; // [R20]
                        next_reject = 1'b0;
                    end
                end
                CMD_RESUME: begin
                    if (state == ST_PAUSED) begin
                        next_state = ST_RUN; // [R20]
                        next_reject = 1'b0;
                    end
                end
                default: begin
                    if (state == ST_IDLE) begin
                        unique case (link_code)
                            CMD_WRITE_ENABLE: begin
                                next_status_low[BIT_LATCH] = 1'b1;
                                next_reject = 1'b0;
                            end
                            CMD_WRITE_DISABLE: begin
                                next_status_low[BIT_LATCH] = 1'b0; // [R19]
                                next_reject = 1'b0;
                            end
                            CMD_STATUS_WRITE: begin
                                // Any refusal leaves every bit alone
                                if (latch && write_allowed) begin // [R4] [R21]
                                    next_status_low[BIT_LOCK_SEL_0] = link_data[7];
                                    next_status_low[BIT_GUARD_LSB +: GUARD_WIDTH] =
                                        link_data[6:2]; // [R5]
                                    next_status_low[BIT_LATCH] = 1'b0; // [R19]
                                    next_status_high[BIT_LOCK_SEL_1] = link_data[8];
                                    next_status_high[BIT_QUAD] = link_data[9]; // [R12]
                                    next_status_high[BIT_SEC_LOCK_LSB +: 2] =
                                        status_high[BIT_SEC_LOCK_LSB +: 2] |
                                        link_data[11:10]; // [R14]
                                    next_status_high[BIT_DUMMY] = link_data[12];
                                    next_status_high[BIT_INVERT] = link_data[14];
                                    next_state = ST_RUN; // [R3]
                                    next_count = 16'(STATUS_CYCLES);
                                    next_reject = 1'b0;
                                end
                            end
                            CMD_PAGE_PROGRAM, CMD_FOUR_KILOBYTE_ERASE, CMD_BLOCK_ERASE: begin
                                if (latch) begin // [R4]
                                    next_status_low[BIT_LATCH] = 1'b0; // [R19]
                                    if (!target_protected) begin // [R5]
                                        next_state = ST_RUN; // [R3]
                                        next_count = (link_code == CMD_PAGE_PROGRAM) ?
                                            16'(PROGRAM_CYCLES) : 16'(ERASE_CYCLES);
                                        next_reject = 1'b0;
                                    end
                                end
                            end
                            CMD_CHIP_ERASE: begin
                                if (latch) begin // [R4]
                                    next_status_low[BIT_LATCH] = 1'b0; // [R19]
                                    if (chip_ok) begin // [R7]
                                        next_state = ST_RUN; // [R3]
                                        next_count = 16'(ERASE_CYCLES);
                                        next_reject = 1'b0;
                                    end
                                end
                            end
                            default: next_reject = 1'b1;
                        endcase
                    end
                end
            endcase
        end
        next_status_low[BIT_BUSY] = next_state == ST_RUN; // [R1] [R3]
        next_status_high[BIT_PAUSED] = next_state == ST_PAUSED; // [R2] [R20]
        next_status_high[BIT_RESERVED] = 1'b0; // [R2]
    end

    // Reset stands for a power cycle: lock selects return to 00 here
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            count <= COUNT_RESET;
            status_low <= LOW_RESET; // [R10] [R19]
            status_high <= HIGH_RESET; // [R14] [R20]
            req_seen <= 1'b0;
            cmd_accept <= 1'b0;
            cmd_reject <= 1'b0;
            dummy_cycles <= DUMMY_LOW;
            quad_mode <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            status_low <= next_status_low;
            status_high <= next_status_high;
            req_seen <= next_req_seen;
            cmd_accept <= new_req & ~next_reject;
            cmd_reject <= next_reject;
            dummy_cycles <= next_status_high[BIT_DUMMY] ? DUMMY_HIGH : DUMMY_LOW; // [R15]
            quad_mode <= next_status_high[BIT_QUAD]; // [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    // A refused command while an operation runs leaves busy high, so only a rise is wrong
    a_latch_gates: assert property (@(posedge clock) disable iff (rst) // [R4]
        new_req && !latch && link_code inside {CMD_STATUS_WRITE, CMD_PAGE_PROGRAM,
        CMD_FOUR_KILOBYTE_ERASE, CMD_BLOCK_ERASE, CMD_CHIP_ERASE}
        |=> cmd_reject && !cmd_accept && !$rose(status_low[BIT_BUSY]))
        else $error("Write command taken with latch clear");

    a_busy_starts: assert property (@(posedge clock) disable iff (rst) // [R3]
        cmd_accept && $rose(status_low[BIT_BUSY]) |-> status_low[BIT_BUSY] [*2])
        else $error("Busy flag did not hold for the operation");

    a_area_refused: assert property (@(posedge clock) disable iff (rst) // [R5]
        new_req && state == ST_IDLE && latch && target_protected &&
        link_code inside {CMD_PAGE_PROGRAM, CMD_FOUR_KILOBYTE_ERASE, CMD_BLOCK_ERASE}
        |=> cmd_reject && !status_low[BIT_BUSY] && !status_low[BIT_LATCH])
        else $error("Program or erase ran inside protected area");

    a_chip_gate: assert property (@(posedge clock) disable iff (rst) // [R7]
        new_req && state == ST_IDLE && link_code == CMD_CHIP_ERASE && latch
        |=> status_low[BIT_BUSY] == $past(chip_ok))
        else $error("Whole erase gating wrong");

    a_pin_lock: assert property (@(posedge clock) disable iff (rst) // [R9]
        new_req && state == ST_IDLE && link_code == CMD_STATUS_WRITE &&
        lock_code == LOCK_PIN && !pin_level
        |=> cmd_reject && $stable(status_low[7:1]) && $stable(status_high[6:0]))
        else $error("Status write passed a low protect pin");

    a_locked_write: assert property (@(posedge clock) disable iff (rst) // [R21]
        new_req && link_code == CMD_STATUS_WRITE && lock_code[1]
        |=> cmd_reject && $stable(status_low[7:1]) && $stable(status_high[6:0]))
        else $error("Status write passed a power or permanent lock");

    a_sec_sticky: assert property (@(posedge clock) disable iff (rst) // [R14]
        !$fell(status_high[BIT_SEC_LOCK_LSB]) && !$fell(status_high[BIT_SEC_LOCK_LSB + 1]))
        else $error("Security lock bit cleared");

    a_suspend_flag: assert property (@(posedge clock) disable iff (rst) // [R20]
        new_req && link_code == CMD_SUSPEND && state == ST_RUN && count > 16'h0001
        |=> status_high[BIT_PAUSED] && !status_low[BIT_BUSY] ##1 $stable(count))
        else $error("Suspend did not pause the operation");

    a_latch_clears: assert property (@(posedge clock) disable iff (rst) // [R19]
        new_req && link_code inside {CMD_WRITE_DISABLE, CMD_SOFT_RESET} |=> !status_low[BIT_LATCH])
        else $error("Latch survived a clearing command");

    a_dummy_count: assert property (@(posedge clock) disable iff (rst) // [R15]
        dummy_cycles == (status_high[BIT_DUMMY] ? DUMMY_HIGH : DUMMY_LOW))
        else $error("Dummy cycle count does not match select bit");

endmodule : fswp_status_protect

// [fswp_host.sv]
// Host-side command issuer on the serial link clock
`timescale 1ns/1ps
module fswp_host (
    input wire logic link_clock,
    input wire logic cmd_ready,
    output logic cmd_valid,
    output fswp_pkg::fswp_cmd_type cmd_code,
    output logic [23:0] cmd_addr,
    output logic [15:0] cmd_data
);
    import fswp_pkg::*;
    initial begin
        cmd_valid = 1'b0;
        cmd_code = CMD_WRITE_DISABLE;
        cmd_addr = 24'h000000;
        cmd_data = 16'h0000;
    end
    // Link clock runs free: the block needs link edges to return its ready
    task automatic send(input fswp_cmd_type c, input logic [23:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge link_clock);
        #1;
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(posedge link_clock);
            #1;
            n++;
        end
        cmd_code = c;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        // Ready only moves on link edges, so the next edge takes it
        @(posedge link_clock);
        #1;
        cmd_valid = 1'b0;
        // Released address and data lines show no stale value, the code line keeps its last value
        cmd_addr = ~a;
        cmd_data = ~d;
    endtask : send
endmodule : fswp_host

// [fswp_status_protect_tb.sv]
// Self-checking bench of the flash status and write-protect block
`timescale 1ns/1ps
module fswp_status_protect_tb;
    import fswp_pkg::*;
    localparam int SC = 8;
    localparam int PC = 16;
    localparam int EC = 32;
    logic clock = 1'b0;
    logic link_clock = 1'b0;
    logic rst = 1'b1;
    logic protect_pin = 1'b0;
    logic cmd_valid, cmd_ready, cmd_accept, cmd_reject, quad_mode;
    fswp_cmd_type cmd_code;
    logic [23:0] cmd_addr;
    logic [15:0] cmd_data;
    logic [7:0] status_low, status_high;
    logic [3:0] dummy_cycles;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    bit ml, m0, m1, mq, md, mi, mp, mr, hold;
    bit [4:0] mg;
    bit [1:0] ms;
    int mlen;
    initial forever #4 clock = ~clock;
    initial begin
        #1.7;
        forever #3 link_clock = ~link_clock;
    end
    fswp_status_protect #(.STATUS_CYCLES(SC), .PROGRAM_CYCLES(PC), .ERASE_CYCLES(EC)) dut (
        .clock(clock), .rst(rst), .link_clock(link_clock), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .protect_pin(protect_pin), .cmd_ready(cmd_ready), .cmd_accept(cmd_accept),
        .cmd_reject(cmd_reject), .status_low(status_low), .status_high(status_high),
        .dummy_cycles(dummy_cycles), .quad_mode(quad_mode));
    fswp_host host (.link_clock(link_clock), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data));
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Protected test for the 256 KB array
    function automatic bit prot(int a);
        int sz;
        bit p;
        if (!mg[4]) sz = (mg[1:0] == 3) ? 'h40000 : mg[1:0] * 'h10000;
        else if (mg[2:0] == 7) sz = 'h40000;
        else sz = (mg[2:0] == 0) ? 0 : (mg[2] ? 'h8000 : ('h800 << mg[1:0]));
        p = mg[3] ? (a < sz) : (a >= 'h40000 - sz);
        return p ^ mi;
    endfunction : prot
    task automatic do_reset();
        rst = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        rst = 1'b0;
        {ml, m0, m1, mq, md, mi, mp, mr, mg, ms} = '0;
        chk("status_reset", 16'h0000, {status_high, status_low});
        chk("ready_dummy_quad_reset", {1'b0, 1'b1, DUMMY_LOW}, {quad_mode, cmd_ready, dummy_cycles});
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmd(fswp_cmd_type c, logic [23:0] a, logic [15:0] d);
        bit acc;
        int n, a18;
        a18 = a[17:0];
        acc = 1;
        mlen = 0;
        if ((mr || mp) && c < CMD_SUSPEND) acc = 0;
        else case (c)
            CMD_WRITE_ENABLE: ml = 1;
            CMD_WRITE_DISABLE: ml = 0;
            CMD_STATUS_WRITE: begin
                acc = ml && !(m1 || (m0 && !protect_pin && !mq));
                if (acc) begin
                    {m0, mg} = d[7:2];
                    {mi, md, ms, mq, m1} = {d[14], d[12], ms | d[11:10], d[9], d[8]};
                    ml = 0;
                    mlen = SC;
                end
            end
            CMD_SUSPEND: begin
                acc = mr && !mp;
                if (acc) mp = 1;
            end
            CMD_RESUME: begin
                acc = mp;
                mp = 0;
            end
            CMD_SOFT_RESET: {ml, mp, mr} = '0;
            default: begin
                acc = ml && (c == CMD_CHIP_ERASE ? (mg[2:0] == {3{mi}}) :
                    !(c == CMD_PAGE_PROGRAM ? prot(a18) : c == CMD_FOUR_KILOBYTE_ERASE ?
                    prot(a18 & 'h3F000) : prot(a18 & 'h30000) | prot(a18 | 'hFFFF)));
                mlen = acc ? ((c == CMD_PAGE_PROGRAM) ? PC : EC) : 0;
                ml = 0;
            end
        endcase
        if (mlen > 0) mr = 1;
        host.send(c, a, d);
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (!(cmd_accept === 1'b1 || cmd_reject === 1'b1) && n < 60);
        chk("cmd_accept", acc, cmd_accept);
        chk("cmd_reject", !acc, cmd_reject);
        chk("status_low", {m0, mg, ml, mr && !mp}, status_low);
        chk("status_high", {mp, mi, 1'b0, md, ms, mq, m1}, status_high);
        chk("dummy_cycles", md ? DUMMY_HIGH : DUMMY_LOW, dummy_cycles);
        chk("quad_mode", mq, quad_mode);
        if (mr && !mp && !hold) begin
            n = 0;
            while (status_low[0] === 1'b1 && n < 200) begin
                @(posedge clock);
                #1;
                n++;
            end
            if (mlen > 0) chk("busy_length", 1, n >= mlen - 2 && n <= mlen);
            chk("busy_done", 0, status_low[0]);
            mr = 0;
        end
    endtask : cmd
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        hold = 0;
        void'($urandom(32'h1d252d02));
        do_reset();
        cmd(CMD_STATUS_WRITE, 0, 16'h001C);
        cmd(CMD_PAGE_PROGRAM, 0, 0);
        // Pin is driven by the bench, never tied, so quad may be set
        repeat (48) begin
            protect_pin = 1'($urandom);
            cmd(CMD_WRITE_ENABLE, 0, 0);
            cmd(CMD_STATUS_WRITE, 0, 16'($urandom) & 16'h5E7C);
            cmd(CMD_WRITE_ENABLE, 0, 0);
            cmd(fswp_cmd_type'(4 + $urandom_range(3, 0)), 24'($urandom), 0);
        end
        do_reset();
        protect_pin = 1'b0;
        cmd(CMD_WRITE_ENABLE, 0, 0);
        cmd(CMD_STATUS_WRITE, 0, 16'h0080);
        cmd(CMD_WRITE_ENABLE, 0, 0);
        cmd(CMD_STATUS_WRITE, 0, 16'h00FC);
        protect_pin = 1'b1;
        cmd(CMD_STATUS_WRITE, 0, 16'h0280);
        protect_pin = 1'b0;
        cmd(CMD_WRITE_ENABLE, 0, 0);
        cmd(CMD_STATUS_WRITE, 0, 16'h0180);
        cmd(CMD_WRITE_ENABLE, 0, 0);
        cmd(CMD_STATUS_WRITE, 0, 16'h0000);
        do_reset();
        cmd(CMD_WRITE_ENABLE, 0, 0);
        cmd(CMD_STATUS_WRITE, 0, 16'h0100);
        cmd(CMD_WRITE_ENABLE, 0, 0);
        cmd(CMD_STATUS_WRITE, 0, 16'h0000);
        do_reset();
        cmd(CMD_WRITE_ENABLE, 0, 0);
        cmd(CMD_WRITE_DISABLE, 0, 0);
        cmd(CMD_PAGE_PROGRAM, 24'h000100, 0);
        repeat (2) begin
            cmd(CMD_WRITE_ENABLE, 0, 0);
            hold = 1;
            cmd(CMD_BLOCK_ERASE, 24'h010000, 0);
            cmd(CMD_SUSPEND, 0, 0);
            hold = 0;
            cmd(CMD_PAGE_PROGRAM, 0, 0);
        end
        cmd(CMD_SOFT_RESET, 0, 0);
        cmd(CMD_WRITE_ENABLE, 0, 0);
        hold = 1;
        cmd(CMD_PAGE_PROGRAM, 24'h020000, 0);
        cmd(CMD_SUSPEND, 0, 0);
        hold = 0;
        cmd(CMD_RESUME, 0, 0);
        end_sim();
    end
endmodule : fswp_status_protect_tb
